// [src/sfs_pkg.sv]
// Shared constants and types of the serial flash front end
package sfs_pkg;
  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
  localparam logic [7:0] CMD_STATUS_RD = 8'h05;
  localparam logic [7:0] CMD_STATUS_WR = 8'h01;
  localparam logic [7:0] CMD_DATA_RD = 8'h03;
  localparam logic [7:0] CMD_PAGE_WR = 8'h02;
  localparam logic [7:0] CMD_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_WIPE = 8'hc7;
  // ****************************************
  // Array geometry and status layout
  // ****************************************
  localparam int MEM_AW = 20;
  localparam int SEC_W = 4;
  localparam int PAGE_W = 8;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [2:0] NB_CMD = 3'h1;
  localparam logic [2:0] NB_STATUS = 3'h2;
  localparam logic [2:0] NB_SECTOR = 3'h4;
  localparam logic [2:0] NB_PAGE = 3'h5;
  localparam logic [2:0] NB_MAX = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam int ST_GUARD_LSB = 2;
  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_GUARD = 8'h04;
  // ****************************************
  // Pin synchroniser lanes and timing
  // ****************************************
  localparam int SY_SCK = 0;
  localparam int SY_CS = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_HOLD = 3;
  localparam int SY_WP = 4;
  // Select looks low at reset so a real falling edge is needed
  localparam logic [4:0] SYNC_RST = 5'h18;
  localparam int CLK_MHZ = 25;
  localparam int STATUS_WR_TIME_NS = 10000;
  localparam int STATUS_WR_CYCLES =
    (STATUS_WR_TIME_NS * CLK_MHZ + 999) / 1000;
  typedef enum {PH_CMD, PH_ADDR, PH_DIN, PH_DOUT_MEM, PH_DOUT_ST,
    PH_DONE} sfs_phase_t;
  typedef enum {WK_IDLE, WK_PROG, WK_ERASE, WK_STATUS} sfs_work_t;
endpackage : sfs_pkg

// [src/sfs_flash_front.sv]
// Serial flash SPI front end with array, page buffer and Wishbone status
// ****************************************
// Notes on behaviour
// - Output bit changes after falling clock edge.
// - Input bits sampled on rising clock edge.
// - Deselected: output is high impedance.
// - Deselected and no internal cycle: standby.
// - Select low makes the device active.
// - Only modes 0 and 3 are supported.
// - Pause keeps selection and bit count.
// - Paused: output off, inputs ignored.
// - Protect pin freezes the guard bits.
// - Page write stays within one 256-byte page.
// - Programming only clears bits.
// - Sector or chip wipe starts erase cycle.
// - Busy flag held during internal cycles.
// - Sixteen sectors of 256 pages of 256 bytes.
// - Latch cleared at reset and after cycles.
// - Writes need clock count multiple of eight.
// - Chip wipe only with all guard bits zero.
// - Pause starts and ends with clock low.
// ****************************************
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module sfs_flash_front #(
  parameter int MEM_AW = sfs_pkg::MEM_AW,
  parameter logic [15:0] STATUS_WR_CYCLES =
    16'(sfs_pkg::STATUS_WR_CYCLES)
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins
  input wire logic shift_timing_in,
  input wire logic chip_enable_n,
  input wire logic mosi_line,
  input wire logic pause_n,
  input wire logic protect_pin_n,
  output logic miso_line,
  output logic miso_line_oe,
  output logic power_active,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);
  localparam int PB = sfs_pkg::PAGE_BYTES;
  localparam int SW = sfs_pkg::SEC_W;
  localparam int PW = sfs_pkg::PAGE_W;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic sckQ;
    logic csQ;
    logic armed;
    logic paused;
    sfs_pkg::sfs_phase_t phase;
    logic [2:0] bitCnt;
    logic [6:0] shIn;
    logic [7:0] opcode;
    logic [2:0] nBytes;
    logic [1:0] addrCnt;
    logic [MEM_AW-1:0] addr;
    logic [PW-1:0] pgPtr;
    logic [PB-1:0] pgValid;
    logic [2:0] pendGuard;
    logic [7:0] outSh;
    logic miso;
    logic misoOe;
    logic latch;
    logic [2:0] guard;
    sfs_pkg::sfs_work_t work;
    logic [MEM_AW-1:0] wAddr;
    logic [MEM_AW-1:0] wEnd;
    logic [15:0] cnt;
    logic active;
    logic ack;
    logic [31:0] dat;
  } sfs_state_t;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [7:0] pgBuf [0:PB-1];

  sfs_state_t st;
  sfs_state_t next_st;
  logic sck, csn, mosi, rise, fall, csRise, sel, ok, wpOk;
  logic wEn, bufWe;
  logic [MEM_AW-1:0] wA, rdA, nAddr;
  logic [7:0] wD, memRd, memOut, bin, spiStatus;

  assign memRd = mem[wA];
  assign memOut = mem[rdA];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    wEn = 1'b0;
    wA = '0;
    wD = '0;
    bufWe = 1'b0;
    next_st.sy1 = {protect_pin_n, pause_n, mosi_line, chip_enable_n,
      shift_timing_in};
    next_st.sy2 = st.sy1;
    sck = st.sy2[sfs_pkg::SY_SCK];
    csn = st.sy2[sfs_pkg::SY_CS];
    mosi = st.sy2[sfs_pkg::SY_MOSI];
    wpOk = st.sy2[sfs_pkg::SY_WP];
    rise = sck & ~st.sckQ;
    fall = ~sck & st.sckQ;
    csRise = csn & ~st.csQ;
    next_st.sckQ = sck;
    next_st.csQ = csn;
    if (~csn & st.csQ) begin
      next_st.armed = 1'b1;
    end
    sel = ~csn & st.armed;
    bin = {st.shIn, mosi};
    nAddr = {st.addr[MEM_AW-9:0], bin};
    rdA = (st.phase == sfs_pkg::PH_ADDR) ? nAddr : st.addr + 1'b1;
    spiStatus = {3'h0, st.guard, st.latch, st.work != sfs_pkg::WK_IDLE};

    // Internal cycles; the latch drops as each one ends
    case (st.work)
      sfs_pkg::WK_PROG: begin
        wA = {st.addr[MEM_AW-1:PW], st.wAddr[PW-1:0]};
        wEn = st.pgValid[st.wAddr[PW-1:0]];
        wD = memRd & pgBuf[st.wAddr[PW-1:0]];
        next_st.wAddr = st.wAddr + 1'b1;
        if (&st.wAddr[PW-1:0]) begin
          next_st.work = sfs_pkg::WK_IDLE;
          next_st.latch = 1'b0;
        end
      end
      sfs_pkg::WK_ERASE: begin
        wA = st.wAddr;
        wEn = 1'b1;
        wD = sfs_pkg::ERASED;
        next_st.wAddr = st.wAddr + 1'b1;
        if (st.wAddr == st.wEnd) begin
          next_st.work = sfs_pkg::WK_IDLE;
          next_st.latch = 1'b0;
        end
      end
      sfs_pkg::WK_STATUS: begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == '0) begin
          next_st.work = sfs_pkg::WK_IDLE;
          next_st.latch = 1'b0;
        end
      end
      default: begin
      end
    endcase

    // Serial protocol
    if (!sel) begin
      next_st.phase = sfs_pkg::PH_CMD;
      next_st.bitCnt = '0;
      next_st.nBytes = '0;
      next_st.paused = 1'b0;
      next_st.misoOe = 1'b0;
    end else begin
      // Pause state only moves while the clock is low
      if (!sck) begin
        next_st.paused = ~st.sy2[sfs_pkg::SY_HOLD];
      end
      next_st.misoOe = ~next_st.paused;
      if (!st.paused && fall) begin
        next_st.miso = st.outSh[7];
        next_st.outSh = {st.outSh[6:0], 1'b0};
      end
      if (!st.paused && rise) begin
        next_st.shIn = bin[6:0];
        next_st.bitCnt = st.bitCnt + 1'b1;
        if (&st.bitCnt) begin
          if (st.nBytes != sfs_pkg::NB_MAX) begin
            next_st.nBytes = st.nBytes + 1'b1;
          end
          case (st.phase)
            sfs_pkg::PH_CMD: begin
              next_st.opcode = bin;
              next_st.addrCnt = '0;
              next_st.phase = sfs_pkg::PH_DONE;
              if (bin == sfs_pkg::CMD_STATUS_RD) begin
                next_st.phase = sfs_pkg::PH_DOUT_ST;
                next_st.outSh = spiStatus;
              end else if (bin == sfs_pkg::CMD_STATUS_WR) begin
                next_st.phase = sfs_pkg::PH_DIN;
              end else if (bin == sfs_pkg::CMD_DATA_RD ||
                  bin == sfs_pkg::CMD_PAGE_WR ||
                  bin == sfs_pkg::CMD_BLOCK_WIPE) begin
                next_st.phase = sfs_pkg::PH_ADDR;
              end
            end
            sfs_pkg::PH_ADDR: begin
              next_st.addr = nAddr;
              next_st.addrCnt = st.addrCnt + 1'b1;
              if (st.addrCnt == sfs_pkg::ADDR_LAST) begin
                next_st.phase = sfs_pkg::PH_DONE;
                if (st.opcode == sfs_pkg::CMD_DATA_RD) begin
                  next_st.phase = sfs_pkg::PH_DOUT_MEM;
                  next_st.outSh = memOut;
                end else if (st.opcode == sfs_pkg::CMD_PAGE_WR) begin
                  next_st.phase = sfs_pkg::PH_DIN;
                  next_st.pgValid = '0;
                  next_st.pgPtr = nAddr[PW-1:0];
                end
              end
            end
            sfs_pkg::PH_DIN: begin
              if (st.opcode == sfs_pkg::CMD_STATUS_WR) begin
                next_st.pendGuard = bin[sfs_pkg::ST_GUARD_LSB +: 3];
                next_st.phase = sfs_pkg::PH_DONE;
              end else if (st.work == sfs_pkg::WK_IDLE) begin
                // Pointer wraps inside the page
                bufWe = 1'b1;
                next_st.pgValid[st.pgPtr] = 1'b1;
                next_st.pgPtr = st.pgPtr + 1'b1;
              end
            end
            sfs_pkg::PH_DOUT_MEM: begin
              next_st.addr = rdA;
              next_st.outSh = memOut;
            end
            sfs_pkg::PH_DOUT_ST: begin
              next_st.outSh = spiStatus;
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Execution on deselect; odd clock counts are dropped
    ok = st.armed && st.bitCnt == '0 && st.work == sfs_pkg::WK_IDLE &&
      st.nBytes != '0;
    if (csRise && ok) begin
      case (st.opcode)
        sfs_pkg::CMD_LATCH_SET: next_st.latch = 1'b1;
        sfs_pkg::CMD_LATCH_CLR: next_st.latch = 1'b0;
        sfs_pkg::CMD_STATUS_WR: begin
          if (st.latch && st.nBytes >= sfs_pkg::NB_STATUS) begin
            if (wpOk) begin
              next_st.guard = st.pendGuard;
            end
            next_st.work = sfs_pkg::WK_STATUS;
            next_st.cnt = STATUS_WR_CYCLES;
          end
        end
        sfs_pkg::CMD_PAGE_WR: begin
          if (st.latch && st.guard == '0 &&
              st.nBytes >= sfs_pkg::NB_PAGE) begin
            next_st.work = sfs_pkg::WK_PROG;
            next_st.wAddr = '0;
          end
        end
        sfs_pkg::CMD_BLOCK_WIPE: begin
          if (st.latch && st.guard == '0 &&
              st.nBytes >= sfs_pkg::NB_SECTOR) begin
            next_st.work = sfs_pkg::WK_ERASE;
            next_st.wAddr = {st.addr[MEM_AW-1 -: SW], {MEM_AW-SW{1'b0}}};
            next_st.wEnd = {st.addr[MEM_AW-1 -: SW], {MEM_AW-SW{1'b1}}};
          end
        end
        sfs_pkg::CMD_CHIP_WIPE: begin
          if (st.latch && st.guard == '0) begin
            next_st.work = sfs_pkg::WK_ERASE;
            next_st.wAddr = '0;
            next_st.wEnd = '1;
          end
        end
        default: begin
        end
      endcase
    end
    next_st.active = ~csn | (next_st.work != sfs_pkg::WK_IDLE);

    // Wishbone slave, one wait state, unmapped reads return zero
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st.dat = '0;
    if (next_st.ack && !wb_we_i &&
        wb_adr_i[7:2] == sfs_pkg::REG_STATUS[7:2]) begin
      next_st.dat = {24'h0, st.active, sel, st.paused, spiStatus[4:0]};
    end else if (next_st.ack && !wb_we_i &&
        wb_adr_i[7:2] == sfs_pkg::REG_GUARD[7:2]) begin
      next_st.dat = {29'h0, st.guard};
    end else if (next_st.ack && wb_we_i && wb_sel_i[0] && wpOk &&
        wb_adr_i[7:2] == sfs_pkg::REG_GUARD[7:2] &&
        next_st.work == sfs_pkg::WK_IDLE) begin
      next_st.guard = wb_dat_i[2:0];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.sy1 <= sfs_pkg::SYNC_RST;
      st.sy2 <= sfs_pkg::SYNC_RST;
      st.outSh <= sfs_pkg::ERASED;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wEn) begin
      mem[wA] <= wD;
    end
    if (bufWe) begin
      pgBuf[st.pgPtr] <= bin;
    end
  end

  assign miso_line = st.miso;
  assign miso_line_oe = st.misoOe;
  assign power_active = st.active;
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_oe_deselect;
    csn |=> !miso_line_oe;
  endproperty
  a_oe_deselect: assert property (p_oe_deselect)
    else $error("output driven while deselected");
  property p_pause_off;
    st.paused |-> !miso_line_oe;
  endproperty
  a_pause_off: assert property (p_pause_off)
    else $error("output driven while paused");
  property p_out_on_fall;
    $changed(miso_line) |-> $past(fall) && $past(sel);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("output changed off a falling edge");
  property p_pause_holds;
    (st.paused && sel) |=> st.bitCnt == $past(st.bitCnt);
  endproperty
  a_pause_holds: assert property (p_pause_holds)
    else $error("bit count moved while paused");
  property p_odd_count;
    (csRise && st.bitCnt != '0 && st.work == sfs_pkg::WK_IDLE)
      |=> st.work == sfs_pkg::WK_IDLE;
  endproperty
  a_odd_count: assert property (p_odd_count)
    else $error("cycle started on odd clock count");
  property p_guard_block;
    (csRise && st.guard != '0 && st.work == sfs_pkg::WK_IDLE)
      |=> st.work == sfs_pkg::WK_IDLE || st.work == sfs_pkg::WK_STATUS;
  endproperty
  a_guard_block: assert property (p_guard_block)
    else $error("erase or program with guard set");
  property p_prog_clears;
    (wEn && st.work == sfs_pkg::WK_PROG) |-> (wD & ~memRd) == 8'h00;
  endproperty
  a_prog_clears: assert property (p_prog_clears)
    else $error("programming set a bit");
  property p_latch_end;
    (st.work != sfs_pkg::WK_IDLE && next_st.work == sfs_pkg::WK_IDLE)
      |=> !st.latch ##1 st.work == sfs_pkg::WK_IDLE;
  endproperty
  a_latch_end: assert property (p_latch_end)
    else $error("latch kept after internal cycle");
  property p_active_sel;
    !csn |=> power_active;
  endproperty
  a_active_sel: assert property (p_active_sel)
    else $error("selected but not active");

  c_prog: cover property (st.work == sfs_pkg::WK_PROG);
  c_erase: cover property (st.work == sfs_pkg::WK_ERASE);
  c_pause: cover property (st.paused && sel);
  c_read: cover property (st.phase == sfs_pkg::PH_DOUT_MEM && fall);
endmodule : sfs_flash_front

// [sim/sfs_host_model.sv]
// Host-side SPI master model that drives the flash pins
`timescale 1ns/1ps
module sfs_host_model (
  // Bench clock
  input wire logic clk,
  // Serial pins
  output logic sck,
  output logic csN,
  output logic mosi,
  output logic holdN,
  output logic wpN,
  // Device answer
  input wire logic miso,
  input wire logic misoOe
);
  // Four system clocks per half period give the 320 ns link clock
  localparam int HALF = 4;
  logic cpol = 1'b0;
  logic lastBit = 1'b0;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    holdN = 1'b1;
    wpN = 1'b1;
  end
  // Pins move only right after a system clock edge
  task half;
    repeat (HALF) @(posedge clk);
  endtask : half
  // Idle level only changes while deselected
  task set_mode(input logic m);
    csN <= 1'b1;
    cpol = m;
    half();
    sck <= m;
    half();
  endtask : set_mode
  // Every frame opens with a fresh select fall
  task select(input logic on);
    if (on) begin
      csN <= 1'b0;
      half();
    end else begin
      half();
      sck <= cpol;
      half();
      csN <= 1'b1;
      half();
      half();
    end
  endtask : select
  // Sample at the end of the high phase; a released line reads as noise
  task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck <= 1'b0;
      mosi <= tx[i];
      half();
      sck <= 1'b1;
      half();
      rx[i] = misoOe ? miso : ~lastBit;
      lastBit = rx[i];
    end
  endtask : xfer
  // Pause only while selected and with the clock low
  task pause(input logic on);
    sck <= 1'b0;
    half();
    holdN <= ~on;
    half();
  endtask : pause
  task junk(input int n);
    repeat (n) begin
      sck <= 1'b1;
      mosi <= ~mosi;
      half();
      sck <= 1'b0;
      half();
    end
  endtask : junk
  // Waits until the synchronised level has reached the logic
  task set_wp(input logic v);
    wpN <= v;
    half();
  endtask : set_wp
endmodule : sfs_host_model

// [sim/sfs_flash_front_tb.sv]
// Self-checking bench of the serial flash front end
`timescale 1ns/1ps
module sfs_flash_front_tb;
  logic clkSys = 1'b0;
  logic rstN;
  logic sck, csN, mosi, holdN, wpN, miso, misoOe, powerActive;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDat;
  logic wbAck;
  logic [31:0] wbDatO;
  int errorCnt = 0;
  int checkCount = 0;
  logic [7:0] rd[$];
  logic [31:0] s;
  always #20 clkSys = ~clkSys;
  sfs_host_model host (.clk(clkSys), .sck(sck), .csN(csN), .mosi(mosi),
    .holdN(holdN), .wpN(wpN), .miso(miso), .misoOe(misoOe));
  // Small array keeps the chip wipe short
  sfs_flash_front #(.MEM_AW(12), .STATUS_WR_CYCLES(16'h0004)) dut (
    .clk_sys(clkSys), .rst_n(rstN), .shift_timing_in(sck),
    .chip_enable_n(csN), .mosi_line(mosi), .pause_n(holdN),
    .protect_pin_n(wpN), .miso_line(miso), .miso_line_oe(misoOe),
    .power_active(powerActive), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_ack_o(wbAck), .wb_dat_o(wbDatO));
  // ****************************************
  // Common tasks
  // ****************************************
  task check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task giveVerdict;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : giveVerdict
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clkSys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= 4'hf;
    @(posedge clkSys);
    while (wbAck !== 1'b1 && n < 100) begin
      @(posedge clkSys);
      n++;
    end
    if (n >= 100) check("wb ack", 1, 0);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb_xfer
  task status;
    wb_xfer(1'b0, sfs_pkg::REG_STATUS, 32'h0, s);
  endtask : status
  task spi_cmd(input logic [7:0] q[$], input int lastN);
    logic [7:0] r;
    host.select(1'b1);
    foreach (q[i]) host.xfer(q[i], (i == q.size() - 1) ? lastN : 8, r);
    host.select(1'b0);
  endtask : spi_cmd
  task spi_read(input logic [23:0] a, input int n);
    logic [7:0] r;
    rd = {};
    host.select(1'b1);
    spi_addr(sfs_pkg::CMD_DATA_RD, a);
    repeat (n) begin
      host.xfer(8'h00, 8, r);
      rd.push_back(r);
    end
    host.select(1'b0);
  endtask : spi_read
  task spi_addr(input logic [7:0] c, input logic [23:0] a);
    logic [7:0] r;
    host.xfer(c, 8, r);
    for (int i = 2; i >= 0; i--) host.xfer(a[i*8 +: 8], 8, r);
  endtask : spi_addr
  task wait_idle;
    int n;
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 3000) begin
      status();
      n++;
    end
    check("busy after cycle", 0, {31'h0, s[0]});
  endtask : wait_idle
  task page_prog(input logic [23:0] a, input logic [7:0] dq[$]);
    logic [7:0] r;
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    host.select(1'b1);
    spi_addr(sfs_pkg::CMD_PAGE_WR, a);
    foreach (dq[i]) host.xfer(dq[i], 8, r);
    host.select(1'b0);
    wait_idle();
  endtask : page_prog
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    check("oe idle", 0, {31'h0, misoOe});
    check("power idle", 0, {31'h0, powerActive});
    status();
    check("status", 0, s & 32'he3);
    wb_xfer(1'b0, 8'h08, 32'h0, s);
    check("unmapped", 0, s);
    $display("reset test done");
  endtask : t_reset
  task t_wipe;
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    status();
    check("latch set", 32'h2, s & 32'h3);
    spi_cmd({sfs_pkg::CMD_CHIP_WIPE}, 8);
    check("power in cycle", 1, {31'h0, powerActive});
    status();
    check("busy in wipe", 32'h1, s & 32'h1);
    wait_idle();
    check("latch after", 0, s & 32'h82);
    spi_read(24'h000ffe, 3);
    check("erased", {8'h0, {3{sfs_pkg::ERASED}}},
      {rd[0], rd[1], rd[2]});
    $display("wipe test done");
  endtask : t_wipe
  task t_program;
    host.set_mode(1'b1);
    page_prog(24'h0001ff, {8'h3c, 8'h77});
    host.set_mode(1'b0);
    spi_read(24'h000100, 1);
    check("page wrap", 32'h77, {24'h0, rd[0]});
    page_prog(24'h0001ff, {8'h0f});
    // Second byte comes from the next, still erased page
    spi_read(24'h0001ff, 2);
    check("clear only", 32'h0cff, {16'h0, rd[0], rd[1]});
    $display("program test done");
  endtask : t_program
  task t_refuse;
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_CHIP_WIPE, 8'h00}, 1);
    status();
    check("odd count", 32'h2, s & 32'h3);
    spi_cmd({sfs_pkg::CMD_LATCH_CLR}, 8);
    status();
    check("latch clear", 0, s & 32'h3);
    $display("refuse test done");
  endtask : t_refuse
  task t_guard;
    wb_xfer(1'b1, sfs_pkg::REG_GUARD, 32'h7, s);
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_CHIP_WIPE}, 8);
    status();
    check("guarded wipe", 32'h1c, s & 32'h1d);
    host.set_wp(1'b0);
    wb_xfer(1'b1, sfs_pkg::REG_GUARD, 32'h0, s);
    wb_xfer(1'b0, sfs_pkg::REG_GUARD, 32'h0, s);
    check("guard frozen", 32'h7, s & 32'h7);
    host.set_wp(1'b1);
    wb_xfer(1'b1, sfs_pkg::REG_GUARD, 32'h0, s);
    wb_xfer(1'b0, sfs_pkg::REG_GUARD, 32'h0, s);
    check("guard open", 0, s & 32'h7);
    spi_cmd({sfs_pkg::CMD_LATCH_CLR}, 8);
    $display("guard test done");
  endtask : t_guard
  task t_pause;
    logic [7:0] r;
    host.select(1'b1);
    spi_addr(sfs_pkg::CMD_DATA_RD, 24'h000100);
    check("oe selected", 1, {31'h0, misoOe});
    host.pause(1'b1);
    status();
    check("paused", 32'h60, s & 32'h60);
    check("oe paused", 0, {31'h0, misoOe});
    host.junk(3);
    host.pause(1'b0);
    host.xfer(8'h00, 8, r);
    host.select(1'b0);
    check("resume byte", 32'h77, {24'h0, r});
    $display("pause test done");
  endtask : t_pause
  task t_cmds;
    logic [7:0] r;
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_STATUS_WR, 8'h1c}, 8);
    wait_idle();
    check("status write latch", 0, s & 32'h2);
    host.select(1'b1);
    host.xfer(sfs_pkg::CMD_STATUS_RD, 8, r);
    host.xfer(8'h00, 8, r);
    host.select(1'b0);
    check("status byte", 32'h1c, {24'h0, r});
    host.set_wp(1'b0);
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_STATUS_WR, 8'h00}, 8);
    wait_idle();
    check("status frozen", 32'h1c, s & 32'h1e);
    host.set_wp(1'b1);
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_STATUS_WR, 8'h00}, 8);
    wait_idle();
    spi_cmd({sfs_pkg::CMD_LATCH_SET}, 8);
    spi_cmd({sfs_pkg::CMD_BLOCK_WIPE, 8'h00, 8'h01, 8'h00}, 8);
    wait_idle();
    check("wipe latch", 0, s & 32'h1e);
    spi_read(24'h000100, 1);
    check("sector erased", 32'hff, {24'h0, rd[0]});
    $display("command test done");
  endtask : t_cmds
  initial begin
    rstN = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDat = 32'h0;
    repeat (3) @(posedge clkSys);
    rstN <= 1'b1;
    // Pin synchronisers leave reset with select low; let them settle
    repeat (4) @(posedge clkSys);
    t_reset();
    t_wipe();
    t_program();
    t_refuse();
    t_guard();
    t_pause();
    t_cmds();
    giveVerdict();
  end
  initial begin
    #3000000;
    errorCnt++;
    giveVerdict();
  end
endmodule : sfs_flash_front_tb
